// ---- design/dac_cmd_pkg.sv ----
package dac_cmd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // frame layout
    localparam int FRAME_BITS = 24;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int WORD_MSB = 15;
    localparam int WORD_W = 16;
    localparam int CMD_W = 4;
    localparam int ADDR_W = 4;
    localparam int BITCNT_W = 5;
    localparam logic [BITCNT_W-1:0] BITCNT_ZERO = 5'h00;
    localparam logic [BITCNT_W-1:0] BITCNT_ONE = 5'h01;
    localparam logic [BITCNT_W-1:0] BITCNT_LAST = 5'h17;
    localparam logic [FRAME_BITS-1:0] FRAME_ZERO = 24'h00_0000;

    ////////////////////////////////////////////////////////////////////////////
    // command codes
    localparam logic [CMD_W-1:0] CMD_NOP = 4'h0;
    localparam logic [CMD_W-1:0] CMD_WRITE_INPUT = 4'h1;
    localparam logic [CMD_W-1:0] CMD_UPDATE_FROM_INPUT = 4'h2;
    localparam logic [CMD_W-1:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [CMD_W-1:0] CMD_POWER = 4'h4;
    localparam logic [CMD_W-1:0] CMD_LOAD_MASK = 4'h5;
    localparam logic [CMD_W-1:0] CMD_SOFT_RESET = 4'h6;
    localparam logic [CMD_W-1:0] CMD_REF_GAIN = 4'h7;
    localparam logic [CMD_W-1:0] CMD_CHAIN = 4'h8;
    localparam logic [CMD_W-1:0] CMD_READBACK = 4'h9;
    localparam logic [CMD_W-1:0] CMD_WRITE_ALL_INPUT = 4'hA;
    localparam logic [CMD_W-1:0] CMD_WRITE_ALL_BOTH = 4'hB;
    localparam logic [CMD_W-1:0] CMD_NOP_CHAIN = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // channels, setting bits and reset values
    localparam int CHANNELS = 8;
    localparam logic [ADDR_W-1:0] ADDR_LIMIT = 4'h8;
    localparam int REF_OFF_BIT = 0;
    localparam int GAIN_BIT = 2;
    localparam int CHAIN_BIT = 0;
    localparam int READBACK_BIT = 0;
    localparam logic [WORD_W-1:0] CODE_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] POWER_RESET = 16'h0000;
    localparam logic [CHANNELS-1:0] MASK_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SYNC_HIGH_MIN_NS = 20;
    localparam int SYNC_HIGH_CYCLES = (SYNC_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCLK_HALF_CYCLES = 4;
    localparam int LOAD_LOW_CYCLES = 4;
    localparam int PHASE_W = 8;

endpackage

// ---- design/dac_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
    logic frame_sync_n;
    logic sclk;
    logic sdi;
    logic sdo;
    logic load_outputs_strobe_n;

    modport device (
        input frame_sync_n,
        input sclk,
        input sdi,
        input load_outputs_strobe_n,
        output sdo
    );

    modport host (
        output frame_sync_n,
        output sclk,
        output sdi,
        output load_outputs_strobe_n,
        input sdo
    );
endinterface
`default_nettype wire

// ---- design/dac_device_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_device_end
    import dac_cmd_pkg::*;
#(
    parameter int CODE_BITS = 16,
    parameter bit GAIN_PIN_VARIANT = 1'b0,
    parameter bit TRANSPARENT_VARIANT = 1'b0
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    dac_link_if.device link,
    input wire logic gain_pin_in,
    output var logic [CHANNELS*WORD_W-1:0] dac_codes_out,
    output var logic [WORD_W-1:0] power_setting_out,
    output var logic [CHANNELS-1:0] load_mask_out,
    output var logic gain_double_out,
    output var logic ref_enable_out,
    output var logic chain_enable_setting_out,
    output var logic readback_enable_out,
    output var logic frame_done_out
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic sync_s1_q, sync_s2_q, sync_s3_q;
    logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic sdi_s1_q, sdi_s2_q;
    logic load_s1_q, load_s2_q;
    logic gain_s1_q, gain_s2_q;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {sync_s1_q, sync_s2_q, sync_s3_q} <= 3'h7;
            {sclk_s1_q, sclk_s2_q, sclk_s3_q} <= 3'h0;
            {sdi_s1_q, sdi_s2_q} <= 2'h0;
            {load_s1_q, load_s2_q} <= 2'h3;
            {gain_s1_q, gain_s2_q} <= 2'h0;
        end else begin
            sync_s1_q <= link.frame_sync_n;
            sync_s2_q <= sync_s1_q;
            sync_s3_q <= sync_s2_q;
            sclk_s1_q <= link.sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            sdi_s1_q <= link.sdi;
            sdi_s2_q <= sdi_s1_q;
            load_s1_q <= link.load_outputs_strobe_n;
            load_s2_q <= load_s1_q;
            gain_s1_q <= gain_pin_in;
            gain_s2_q <= gain_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // edge decode
    wire frame_active = ~sync_s2_q;
    // falling clock edge inside a frame
    wire bit_take = frame_active & sclk_s3_q & ~sclk_s2_q;
    wire frame_end = sync_s2_q & ~sync_s3_q;
    wire frame_start = ~sync_s2_q & sync_s3_q;
    // strobe low only counts between frames
    wire load_level = ~load_s2_q & sync_s2_q;

    ////////////////////////////////////////////////////////////////////////////
    // shift register
    logic [FRAME_BITS-1:0] shift_q;
    logic [BITCNT_W-1:0] bit_cnt_q;
    logic sdo_q;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shift_q <= FRAME_ZERO;
            bit_cnt_q <= BITCNT_ZERO;
        end else if (frame_start) begin
            bit_cnt_q <= BITCNT_ZERO;
        end else if (bit_take && bit_cnt_q <= BITCNT_LAST) begin
            // msb arrives first and ends at the top
            shift_q <= {shift_q[FRAME_BITS-2:0], sdi_s2_q};
            bit_cnt_q <= bit_cnt_q + BITCNT_ONE;
        end
    end

    // chained mode pushes the displaced bit out
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sdo_q <= 1'b0;
        end else if (bit_take) begin
            sdo_q <= chain_enable_setting_out & shift_q[FRAME_BITS-1];
        end
    end

    assign link.sdo = sdo_q;

    ////////////////////////////////////////////////////////////////////////////
    // field decode
    // fixed field positions
    wire [CMD_W-1:0] command_field = shift_q[CMD_MSB:CMD_LSB];
    wire [ADDR_W-1:0] channel_address_field = shift_q[ADDR_MSB:ADDR_LSB];
    // clear the don't-care low bits of a short code
    wire [WORD_W-1:0] code_keep = ~((WORD_W'(1) << (WORD_W - CODE_BITS)) - WORD_W'(1));
    wire [WORD_W-1:0] data_word = shift_q[WORD_MSB:0] & code_keep;
    wire [WORD_W-1:0] raw_word = shift_q[WORD_MSB:0];
    // out of range address drops the frame
    wire addr_ok = channel_address_field < ADDR_LIMIT;
    // a short frame executes with whatever was shifted
    wire exec = frame_end & addr_ok;
    // no-op codes and reserved codes match no decode below
    wire is_wr_in = exec & (command_field == CMD_WRITE_INPUT);
    wire is_upd = exec & (command_field == CMD_UPDATE_FROM_INPUT);
    wire is_wr_upd = exec & (command_field == CMD_WRITE_UPDATE);
    wire is_power = exec & (command_field == CMD_POWER);
    wire is_mask = exec & (command_field == CMD_LOAD_MASK);
    wire is_reset = exec & (command_field == CMD_SOFT_RESET);
    wire is_ref_gain = exec & (command_field == CMD_REF_GAIN);
    wire is_chain = exec & (command_field == CMD_CHAIN);
    wire is_readback = exec & (command_field == CMD_READBACK);
    wire is_all_in = exec & (command_field == CMD_WRITE_ALL_INPUT);
    wire is_all_both = exec & (command_field == CMD_WRITE_ALL_BOTH);
    wire pass_through = TRANSPARENT_VARIANT | ~load_s2_q;

    ////////////////////////////////////////////////////////////////////////////
    // per channel next values
    logic [CHANNELS*WORD_W-1:0] input_regs_q;
    wire [CHANNELS*WORD_W-1:0] input_regs_d;
    wire [CHANNELS*WORD_W-1:0] dac_codes_d;

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        wire hit = (channel_address_field == ADDR_W'(ch));
        wire in_wr = (is_wr_in & hit) | (is_wr_upd & hit) | is_all_in | is_all_both;
        // input writes pass through when transparent and unmasked
        wire in_pass = ((is_wr_in & hit) | is_all_in) & pass_through & ~load_mask_out[ch];
        wire out_wr = (is_wr_upd & hit) | is_all_both | in_pass;
        // update picks channels by data bit; strobe copies unmasked
        wire out_copy = (is_upd & raw_word[ch]) | (load_level & ~load_mask_out[ch]);
        wire [WORD_W-1:0] in_now = input_regs_q[ch*WORD_W +: WORD_W];
        wire [WORD_W-1:0] out_now = dac_codes_out[ch*WORD_W +: WORD_W];
        assign input_regs_d[ch*WORD_W +: WORD_W] = in_wr ? data_word : in_now;
        assign dac_codes_d[ch*WORD_W +: WORD_W] = out_wr ? data_word : (out_copy ? in_now : out_now);
    end

    ////////////////////////////////////////////////////////////////////////////
    // code registers
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            input_regs_q <= {CHANNELS{CODE_RESET}};
            dac_codes_out <= {CHANNELS{CODE_RESET}};
        end else if (is_reset) begin
            input_regs_q <= {CHANNELS{CODE_RESET}};
            dac_codes_out <= {CHANNELS{CODE_RESET}};
        end else begin
            input_regs_q <= input_regs_d;
            dac_codes_out <= dac_codes_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // settings
    logic gain_bit_q;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            power_setting_out <= POWER_RESET;
            load_mask_out <= MASK_RESET;
            gain_bit_q <= 1'b0;
            ref_enable_out <= 1'b1;
            chain_enable_setting_out <= 1'b0;
            readback_enable_out <= 1'b0;
        end else if (is_reset) begin
            power_setting_out <= POWER_RESET;
            load_mask_out <= MASK_RESET;
            gain_bit_q <= 1'b0;
            ref_enable_out <= 1'b1;
            chain_enable_setting_out <= 1'b0;
            readback_enable_out <= 1'b0;
        end else begin
            if (is_power) begin
                power_setting_out <= raw_word;
            end
            if (is_mask) begin
                load_mask_out <= raw_word[CHANNELS-1:0];
            end
            if (is_ref_gain) begin
                gain_bit_q <= raw_word[GAIN_BIT];
                ref_enable_out <= ~raw_word[REF_OFF_BIT];
            end
            if (is_chain) begin
                chain_enable_setting_out <= raw_word[CHAIN_BIT];
            end
            if (is_readback) begin
                readback_enable_out <= raw_word[READBACK_BIT];
            end
        end
    end

    // pin variant ignores the gain bit
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            gain_double_out <= 1'b0;
            frame_done_out <= 1'b0;
        end else begin
            gain_double_out <= GAIN_PIN_VARIANT ? gain_s2_q : gain_bit_q;
            frame_done_out <= frame_end;
        end
    end

endmodule
`default_nettype wire

// ---- design/dac_host_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_host_end
    import dac_cmd_pkg::*;
#(
    parameter int HALF_CYCLES = SCLK_HALF_CYCLES,
    parameter int LOAD_CYCLES = LOAD_LOW_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    dac_link_if.host link,
    input wire logic send_in,
    input wire logic [CMD_W-1:0] command_in,
    input wire logic [ADDR_W-1:0] address_in,
    input wire logic [WORD_W-1:0] data_in,
    input wire logic load_in,
    output var logic busy_out,
    output var logic done_out,
    output var logic [FRAME_BITS-1:0] echo_word_out
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_GAP = 2'b11,
        ST_LOAD = 2'b10
    } host_state_e;

    localparam logic [PHASE_W-1:0] HALF = PHASE_W'(HALF_CYCLES);
    localparam logic [PHASE_W-1:0] PERIOD_END = PHASE_W'(2 * HALF_CYCLES - 1);
    localparam int GAP_RAW = (SYNC_HIGH_CYCLES > 2 * HALF_CYCLES) ? SYNC_HIGH_CYCLES : 2 * HALF_CYCLES;
    localparam logic [PHASE_W-1:0] GAP_END = PHASE_W'(GAP_RAW - 1);
    localparam logic [PHASE_W-1:0] LOAD_END = PHASE_W'(LOAD_CYCLES - 1);
    localparam logic [PHASE_W-1:0] PHASE_ZERO = 8'h00;
    localparam logic [PHASE_W-1:0] PHASE_ONE = 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    // echo input synchroniser
    logic sdo_s1_q, sdo_s2_q;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {sdo_s1_q, sdo_s2_q} <= 2'h0;
        end else begin
            sdo_s1_q <= link.sdo;
            sdo_s2_q <= sdo_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer
    host_state_e state_q;
    logic [PHASE_W-1:0] phase_q;
    logic [BITCNT_W-1:0] bit_cnt_q;
    logic [FRAME_BITS-1:0] tx_q;
    logic sync_n_q, sclk_q, sdi_q, load_n_q;

    wire phase_wrap = (phase_q == PERIOD_END);
    wire last_bit = (bit_cnt_q == BITCNT_LAST);

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= ST_IDLE;
            phase_q <= PHASE_ZERO;
            bit_cnt_q <= BITCNT_ZERO;
            tx_q <= FRAME_ZERO;
            echo_word_out <= FRAME_ZERO;
            sync_n_q <= 1'b1;
            sclk_q <= 1'b0;
            sdi_q <= 1'b0;
            load_n_q <= 1'b1;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    phase_q <= PHASE_ZERO;
                    bit_cnt_q <= BITCNT_ZERO;
                    if (send_in) begin
                        tx_q <= {command_in, address_in, data_in};
                        sync_n_q <= 1'b0;
                        busy_out <= 1'b1;
                        state_q <= ST_SHIFT;
                    end else if (load_in) begin
                        // strobe only while sync is high
                        load_n_q <= 1'b0;
                        busy_out <= 1'b1;
                        state_q <= ST_LOAD;
                    end
                end
                ST_SHIFT: begin
                    phase_q <= phase_wrap ? PHASE_ZERO : phase_q + PHASE_ONE;
                    if (phase_q == PHASE_ZERO) begin
                        sdi_q <= tx_q[FRAME_BITS-1];
                        sclk_q <= 1'b1;
                        echo_word_out <= {echo_word_out[FRAME_BITS-2:0], sdo_s2_q};
                    end else if (phase_q == HALF) begin
                        sclk_q <= 1'b0;
                    end
                    if (phase_wrap) begin
                        tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + BITCNT_ONE;
                        if (last_bit) begin
                            // raise sync after the 24th bit
                            sync_n_q <= 1'b1;
                            state_q <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    // hold sync high before the next frame
                    phase_q <= phase_q + PHASE_ONE;
                    if (phase_q == GAP_END) begin
                        busy_out <= 1'b0;
                        done_out <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_LOAD: begin
                    phase_q <= phase_q + PHASE_ONE;
                    if (phase_q == LOAD_END) begin
                        load_n_q <= 1'b1;
                        busy_out <= 1'b0;
                        done_out <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.frame_sync_n = sync_n_q;
    assign link.sclk = sclk_q;
    assign link.sdi = sdi_q;
    assign link.load_outputs_strobe_n = load_n_q;

endmodule
`default_nettype wire

// ---- bench/dac_link_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_link_monitor (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic frame_sync_n,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic load_outputs_strobe_n
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    ////////////////////////////////////////////////////////////////////////////
    // falling serial clock edges seen inside the current frame
    logic sclk_q;
    logic [5:0] falls_q;
    logic [5:0] falls_d;
    wire logic fall_seen = sclk_q & ~sclk;
    assign falls_d = frame_sync_n ? 6'h00 : falls_q + {5'h00, fall_seen};
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sclk_q <= 1'b0;
            falls_q <= 6'h00;
        end else begin
            sclk_q <= sclk;
            falls_q <= falls_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // steps of a frame
    sequence clk_high_s;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence clk_low_s;
        !sclk [*4];
    endsequence
    sequence frame_low_s;
        ##191 !frame_sync_n ##1 frame_sync_n;
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    sclk_idle_low_a: assert property (frame_sync_n |-> !sclk)
        else $error("serial clock high outside a frame");
    sync_before_data_a: assert property ($fell(frame_sync_n) |-> !$past(sclk))
        else $error("frame started with serial clock high");
    frame_length_a: assert property ($fell(frame_sync_n) |-> frame_low_s)
        else $error("frame select low for wrong length");
    bit_count_a: assert property ($rose(frame_sync_n) |-> falls_q == 6'h18)
        else $error("frame closed without 24 falling clocks");
    data_stable_a: assert property ($fell(sclk) |-> $stable(sdi))
        else $error("serial data changed at falling clock");
    clk_high_time_a: assert property ($rose(sclk) |-> clk_high_s)
        else $error("serial clock high phase wrong");
    clk_low_time_a: assert property ($fell(sclk) |-> clk_low_s)
        else $error("serial clock low phase too short");
    sync_gap_a: assert property ($rose(frame_sync_n) |-> frame_sync_n [*3])
        else $error("frame select gap too short");
    strobe_in_gap_a: assert property (!load_outputs_strobe_n |-> frame_sync_n)
        else $error("load strobe low inside a frame");
    strobe_width_a: assert property ($fell(load_outputs_strobe_n) |->
        !load_outputs_strobe_n [*4] ##1 load_outputs_strobe_n)
        else $error("load strobe pulse width wrong");
    sdo_in_frame_a: assert property ($changed(sdo) |-> !$past(frame_sync_n))
        else $error("serial output changed outside a frame");
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
    import dac_cmd_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic send_in = 1'b0;
    logic load_in = 1'b0;
    logic gain_pin_in = 1'b1;
    logic [CMD_W-1:0] command_in = 4'h0;
    logic [ADDR_W-1:0] address_in = 4'h0;
    logic [WORD_W-1:0] data_in = 16'h0000;
    logic busy_out, done_out, frame_done_out, gain_double_out, ref_enable_out;
    logic chain_enable_setting_out, readback_enable_out;
    logic [FRAME_BITS-1:0] echo_word_out;
    logic [CHANNELS*WORD_W-1:0] dac_codes_out;
    logic [WORD_W-1:0] power_setting_out;
    logic [CHANNELS-1:0] load_mask_out;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    dac_link_if link_bus ();
    dac_host_end u_dac_host_end (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .link(link_bus),
        .send_in(send_in), .command_in(command_in), .address_in(address_in), .data_in(data_in),
        .load_in(load_in), .busy_out(busy_out), .done_out(done_out), .echo_word_out(echo_word_out));
    dac_device_end u_dac_device_end (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .link(link_bus),
        .gain_pin_in(gain_pin_in), .dac_codes_out(dac_codes_out), .power_setting_out(power_setting_out),
        .load_mask_out(load_mask_out), .gain_double_out(gain_double_out), .ref_enable_out(ref_enable_out),
        .chain_enable_setting_out(chain_enable_setting_out), .readback_enable_out(readback_enable_out),
        .frame_done_out(frame_done_out));
    dac_link_monitor u_dac_link_monitor (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .frame_sync_n(link_bus.frame_sync_n), .sclk(link_bus.sclk), .sdi(link_bus.sdi), .sdo(link_bus.sdo),
        .load_outputs_strobe_n(link_bus.load_outputs_strobe_n));

    always #(CLK_PERIOD_NS / 2) core_clk_in = ~core_clk_in;

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one frame (strobe low) or one load pulse (strobe high), then let the device settle
    task automatic run(input logic strobe, input logic [FRAME_BITS-1:0] word);
        int n;
        logic fd;
        n = 0;
        fd = 1'b0;
        if (strobe) begin
            load_in <= 1'b1;
        end else begin
            {command_in, address_in, data_in} <= word;
            send_in <= 1'b1;
        end
        @(posedge core_clk_in);
        send_in <= 1'b0;
        load_in <= 1'b0;
        do begin
            @(posedge core_clk_in);
            #1;
            n++;
            if (n == 1) check("busy high", 1, busy_out);
            fd = fd | frame_done_out;
        end while (done_out !== 1'b1 && n < 400);
        if (n >= 400) check("host done", 1, 0);
        check("busy low", 0, busy_out);
        check("frame done", !strobe, fd);
        repeat (8) @(posedge core_clk_in);
    endtask

    task automatic t_reset(input string name);
        check("codes", '0, dac_codes_out);
        check("reference on", 1, ref_enable_out);
        check("gain", 0, gain_double_out);
        check("chain", 0, chain_enable_setting_out);
        check("settings", '0, {power_setting_out, load_mask_out, readback_enable_out});
        $display("test done: %s", name);
    endtask

    task automatic t_single();
        run(0, 24'h13_A5A5);
        check("input only", '0, dac_codes_out);
        check("echo standalone", '0, echo_word_out);
        run(0, 24'h20_0008);
        check("update ch3", 128'h0000_0000_0000_0000_A5A5_0000_0000_0000, dac_codes_out);
        run(0, 24'h37_1234);
        check("direct ch7", 128'h1234_0000_0000_0000_A5A5_0000_0000_0000, dac_codes_out);
        $display("test done: single channel");
    endtask

    task automatic t_all();
        run(0, 24'hA0_5555);
        check("all input", 128'h1234_0000_0000_0000_A5A5_0000_0000_0000, dac_codes_out);
        run(1, '0);
        check("strobe load", {8{16'h5555}}, dac_codes_out);
        run(0, 24'hB0_0F0F);
        check("all both", {8{16'h0F0F}}, dac_codes_out);
        $display("test done: broadcast and strobe");
    endtask

    task automatic t_config();
        run(0, 24'h50_0001);
        check("mask", 8'h01, load_mask_out);
        run(0, 24'hA0_C3C3);
        run(1, '0);
        check("masked strobe", {{7{16'hC3C3}}, 16'h0F0F}, dac_codes_out);
        run(0, 24'h40_00F3);
        check("power", 16'h00F3, power_setting_out);
        run(0, 24'h70_0005);
        check("ref and gain", 2'b10, {gain_double_out, ref_enable_out});
        run(0, 24'h80_0001);
        check("chain", 1, chain_enable_setting_out);
        run(0, 24'h90_0001);
        check("readback", 1, readback_enable_out);
        $display("test done: settings");
    endtask

    task automatic t_ignored();
        logic [3:0] codes [5] = '{4'h0, 4'hC, 4'hD, 4'hE, 4'hF};
        foreach (codes[i]) begin
            run(0, {codes[i], 4'h2, 16'hFFFF});
            check("no effect", {{7{16'hC3C3}}, 16'h0F0F}, dac_codes_out);
        end
        run(0, 24'h38_7777);
        check("high address", {{7{16'hC3C3}}, 16'h0F0F}, dac_codes_out);
        run(0, 24'h69_0000);
        check("reset dropped", 2'b11, {gain_double_out, chain_enable_setting_out});
        $display("test done: ignored frames");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge core_clk_in);
        t_reset("reset values");
        t_single();
        t_all();
        t_config();
        t_ignored();
        run(0, 24'h60_0000);
        t_reset("soft reset");
        give_verdict();
    end
endmodule
`default_nettype wire
